// *** hw/move_mul_pkg.sv ***
`default_nettype none
package move_mul_pkg;
    localparam int          DATA_AW          = 12;
    localparam int          DATA_W           = 8;
    localparam int          INSTR_W          = 16;
    localparam int          MEM_DEPTH        = 4096;
    localparam logic [3:0]  OP_MOVE_SRC      = 4'hC;
    localparam logic [3:0]  OP_MOVE_DST      = 4'hF;
    localparam logic [7:0]  OP_LOAD_BANK     = 8'h01;
    localparam logic [7:0]  OP_LOAD_WORK     = 8'h0E;
    localparam logic [7:0]  OP_MUL_LIT       = 8'h0D;
    localparam logic [6:0]  OP_STORE_WORK    = 7'h37;
    localparam logic [11:0] WORKING_ADDR     = 12'hFE0;
    localparam logic [11:0] PC_LOW_ADDR      = 12'hFE1;
    localparam logic [11:0] STACK_LOW_ADDR   = 12'hFE2;
    localparam logic [11:0] STACK_HIGH_ADDR  = 12'hFE3;
    localparam logic [11:0] STACK_UPPER_ADDR = 12'hFE4;
    localparam logic [7:0]  ACCESS_SPLIT     = 8'h80;
    localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
    localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0]  WORK_RESET       = 8'h00;
    localparam logic [7:0]  BANK_RESET       = 8'h00;
    localparam logic [7:0]  PROD_RESET       = 8'h00;
endpackage
`default_nettype wire

// *** hw/data_mem_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface data_mem_if;
    logic [11:0] rd_addr;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic [11:0] wr_addr;
    logic        wr_en;
    logic [7:0]  wr_data;
    modport core (output rd_addr, output rd_en, input rd_data,
                  output wr_addr, output wr_en, output wr_data);
    modport mem  (input rd_addr, input rd_en, output rd_data,
                  input wr_addr, input wr_en, input wr_data);
endinterface
`default_nettype wire

// *** hw/data_space_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module data_space_mem (
    input  wire logic    clock_i,
    data_mem_if.mem      bus
);
    logic [7:0] cells [0:move_mul_pkg::MEM_DEPTH-1];

    always_ff @(posedge clock_i)
    begin
        if (bus.wr_en)
        begin
            cells[bus.wr_addr] <= bus.wr_data;
        end
    end

    // registered read: data appear one edge after the request
    always_ff @(posedge clock_i)
    begin
        if (bus.rd_en)
        begin
            bus.rd_data <= cells[bus.rd_addr];
        end
    end
endmodule
`default_nettype wire

// *** hw/move_and_multiply_instr_exec.sv ***
// Function
// RULE_01: A full-space move is a word with top nibble 1100 and a source address followed by a word with top nibble 1111 and a destination address.
// RULE_02: Both move addresses are full 12-bit and reach every byte 000h to FFFh with no bank selection.
// RULE_03: The move may take the working register as source or destination and copies the byte unchanged.
// RULE_04: The move never writes the program counter low byte or any of the three stack top bytes.
// RULE_05: The move takes two words and two cycles, three if the second word is late, reading first and writing at the end of the second.
// RULE_06: Opcode 0000 0001 loads its literal into the bank select register in one cycle, flags untouched.
// RULE_07: Opcode 0000 1110 loads its literal into the working register in one cycle, flags untouched.
// RULE_08: Encoding 0110 111a stores the working register to the addressed file byte in one cycle, flags untouched.
// RULE_09: Access bit 0 selects the access bank, access bit 1 selects the bank named by the bank select register.
// RULE_10: The 8-bit file address reaches any byte of the chosen 256-byte bank.
// RULE_11: Opcode 0000 1101 puts the unsigned product of working register and literal into product high and low, working register kept.
// RULE_12: The literal multiply finishes in one cycle and changes no status flag, even for a zero product.
`timescale 1ns/100ps
`default_nettype none
module move_and_multiply_instr_exec (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_word_i,
    output logic             instr_ready_o,
    output logic [7:0]       working_register_o,
    output logic [7:0]       bank_select_register_o,
    output logic [7:0]       product_high_o,
    output logic [7:0]       product_low_o,
    output logic             move_busy_o,
    output logic             illegal_dest_o,
    output logic             move_broken_o
);
    typedef enum logic [0:0] {IDLE, WAIT_DEST} move_state_e;

    move_state_e state;
    logic        src_is_work;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
    logic        take;
    logic [3:0]  top_nibble;
    logic [7:0]  top_byte;
    logic [7:0]  literal;
    logic [11:0] dest_addr;
    logic [7:0]  move_data;
    logic        move_commit;
    logic        dest_blocked;
    logic [11:0] store_addr;
    logic        do_store;
    logic [15:0] product;

    data_mem_if mem_bus ();

    data_space_mem u_mem (
        .clock_i (clock_i),
        .bus     (mem_bus)
    );

    // only the access and banked paths; full-space addresses bypass this
    function automatic logic [11:0] banked_addr(input logic       access_bit,
                                                input logic [7:0] bank,
                                                input logic [7:0] offset);
        logic [3:0] sel;
        sel = (offset < move_mul_pkg::ACCESS_SPLIT) ? move_mul_pkg::ACCESS_LOW_BANK
                                                    : move_mul_pkg::ACCESS_HIGH_BANK;
        if (access_bit)
        begin
            sel = bank[3:0];
        end
        return {sel, offset};
    endfunction

    function automatic logic is_protected(input logic [11:0] addr);
        return (addr == move_mul_pkg::PC_LOW_ADDR)
            || (addr == move_mul_pkg::STACK_LOW_ADDR)
            || (addr == move_mul_pkg::STACK_HIGH_ADDR)
            || (addr == move_mul_pkg::STACK_UPPER_ADDR);
    endfunction

    assign take       = instr_valid_i && instr_ready_o;
    assign top_nibble = instr_word_i[15:12];
    assign top_byte   = instr_word_i[15:8];
    assign literal    = instr_word_i[7:0];
    assign dest_addr  = instr_word_i[11:0];
    // widened before the multiply so the top byte is never lost
    assign product    = 16'(working_register) * 16'(literal);

    // read data stay in the memory register until the second word
    // RULE_03: source byte unchanged
    assign move_data    = src_is_work ? working_register : mem_bus.rd_data;
    assign move_commit  = take && (state == WAIT_DEST) && (top_nibble == move_mul_pkg::OP_MOVE_DST);
    // RULE_04: guarded destinations
    assign dest_blocked = is_protected(dest_addr);
    // RULE_09: access or banked select
    // RULE_10: full 8-bit offset
    assign store_addr   = banked_addr(instr_word_i[8], bank_select_register, literal);
    // RULE_08: store decode
    assign do_store     = take && (state == IDLE)
                       && (instr_word_i[15:9] == move_mul_pkg::OP_STORE_WORK);

    // RULE_02: 12-bit source read
    assign mem_bus.rd_addr = instr_word_i[11:0];
    assign mem_bus.rd_en   = take && (state == IDLE) && (top_nibble == move_mul_pkg::OP_MOVE_SRC);

    always_comb
    begin
        mem_bus.wr_en   = 1'b0;
        mem_bus.wr_addr = store_addr;
        mem_bus.wr_data = working_register;
        if (move_commit && !dest_blocked && (dest_addr != move_mul_pkg::WORKING_ADDR))
        begin
            mem_bus.wr_en   = 1'b1;
            mem_bus.wr_addr = dest_addr;
            mem_bus.wr_data = move_data;
        end
        else if (do_store && (store_addr != move_mul_pkg::WORKING_ADDR))
        begin
            mem_bus.wr_en = 1'b1;
        end
    end

    // RULE_01: two-word sequence
    // RULE_05: read then late write
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state       <= IDLE;
            src_is_work <= 1'b0;
        end
        else if (take)
        begin
            case (state)
                IDLE:
                begin
                    if (top_nibble == move_mul_pkg::OP_MOVE_SRC)
                    begin
                        state       <= WAIT_DEST;
                        src_is_work <= (instr_word_i[11:0] == move_mul_pkg::WORKING_ADDR);
                    end
                end
                WAIT_DEST:
                begin
                    state <= IDLE;
                end
                default:
                begin
                    state <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            working_register <= move_mul_pkg::WORK_RESET;
        end
        else if (move_commit && !dest_blocked && (dest_addr == move_mul_pkg::WORKING_ADDR))
        begin
            working_register <= move_data;
        end
        // RULE_07: literal to working
        else if (take && (state == IDLE) && (top_byte == move_mul_pkg::OP_LOAD_WORK))
        begin
            working_register <= literal;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            bank_select_register <= move_mul_pkg::BANK_RESET;
        end
        // RULE_06: literal to bank select
        else if (take && (state == IDLE) && (top_byte == move_mul_pkg::OP_LOAD_BANK))
        begin
            bank_select_register <= literal;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            product_high_o <= move_mul_pkg::PROD_RESET;
            product_low_o  <= move_mul_pkg::PROD_RESET;
        end
        // RULE_11: unsigned product split
        // RULE_12: one cycle, no flags
        else if (take && (state == IDLE) && (top_byte == move_mul_pkg::OP_MUL_LIT))
        begin
            product_high_o <= product[15:8];
            product_low_o  <= product[7:0];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            instr_ready_o  <= 1'b0;
            move_busy_o    <= 1'b0;
            illegal_dest_o <= 1'b0;
            move_broken_o  <= 1'b0;
        end
        else
        begin
            // no back-pressure: every word is taken once out of reset
            instr_ready_o  <= 1'b1;
            move_busy_o    <= (state == WAIT_DEST) ? !take : mem_bus.rd_en;
            // RULE_04: report refused write
            illegal_dest_o <= move_commit && dest_blocked;
            // orphan first word: move dropped, word itself ignored
            move_broken_o  <= take && (state == WAIT_DEST)
                           && (top_nibble != move_mul_pkg::OP_MOVE_DST);
        end
    end

    assign working_register_o     = working_register;
    assign bank_select_register_o = bank_select_register;
endmodule
`default_nettype wire

// *** test/move_and_multiply_instr_exec_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module move_and_multiply_instr_exec_asserts (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_word_i,
    input wire logic        instr_ready_o,
    input wire logic [7:0]  working_register_o,
    input wire logic [7:0]  bank_select_register_o,
    input wire logic [7:0]  product_high_o,
    input wire logic [7:0]  product_low_o,
    input wire logic        move_busy_o,
    input wire logic        illegal_dest_o,
    input wire logic        move_broken_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    logic single;
    assign take = instr_valid_i && instr_ready_o;
    assign single = take && !move_busy_o;
    sequence first_word;
        single && instr_word_i[15:12] == 4'hC;
    endsequence
    sequence second_word;
        take && move_busy_o;
    endsequence
    chk_load_work: assert property (single && instr_word_i[15:8] == 8'h0E
        |=> working_register_o == $past(instr_word_i[7:0])) else $error("working load wrong");
    chk_load_bank: assert property (single && instr_word_i[15:8] == 8'h01
        |=> bank_select_register_o == $past(instr_word_i[7:0])) else $error("bank load wrong");
    chk_mul_product: assert property (single && instr_word_i[15:8] == 8'h0D
        |=> {product_high_o, product_low_o} == 16'($past(working_register_o))
            * 16'($past(instr_word_i[7:0]))) else $error("product wrong");
    chk_mul_keeps_work: assert property (single && instr_word_i[15:8] == 8'h0D
        |=> $stable(working_register_o)) else $error("multiply changed working");
    chk_move_busy_set: assert property (first_word |=> move_busy_o) else $error("busy not set");
    chk_move_busy_end: assert property (second_word |=> !move_busy_o) else $error("busy stuck");
    chk_protected_dest: assert property (second_word ##0 instr_word_i[15:12] == 4'hF
        && instr_word_i[11:0] inside {[12'hFE1:12'hFE4]} |=> illegal_dest_o ##1 !illegal_dest_o)
        else $error("protected pulse wrong");
    chk_bad_second: assert property (second_word ##0 instr_word_i[15:12] != 4'hF
        |=> move_broken_o) else $error("broken move not flagged");
endmodule
bind move_and_multiply_instr_exec move_and_multiply_instr_exec_asserts u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
    .working_register_o(working_register_o), .bank_select_register_o(bank_select_register_o),
    .product_high_o(product_high_o), .product_low_o(product_low_o), .move_busy_o(move_busy_o),
    .illegal_dest_o(illegal_dest_o), .move_broken_o(move_broken_o));
`default_nettype wire

// *** test/move_and_multiply_instr_exec_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module move_and_multiply_instr_exec_tb_top;
    logic        clock_i;
    logic        rst_n_i = 1'b0;
    logic        instr_valid_i = 1'b0;
    logic [15:0] instr_word_i = 16'h0000;
    logic        instr_ready_o;
    logic [7:0]  working_register_o;
    logic [7:0]  bank_select_register_o;
    logic [7:0]  product_high_o;
    logic [7:0]  product_low_o;
    logic        move_busy_o;
    logic        illegal_dest_o;
    logic        move_broken_o;
    int          mismatches = 0;
    int          checks = 0;
    move_and_multiply_instr_exec dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
        .working_register_o(working_register_o), .bank_select_register_o(bank_select_register_o),
        .product_high_o(product_high_o), .product_low_o(product_low_o), .move_busy_o(move_busy_o),
        .illegal_dest_o(illegal_dest_o), .move_broken_o(move_broken_o));
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // valid stays up so words can follow back to back
    task automatic send(input logic [15:0] w);
        instr_valid_i = 1'b1;
        instr_word_i = w;
        @(negedge clock_i);
    endtask
    task automatic idle;
        instr_valid_i = 1'b0;
        @(negedge clock_i);
    endtask
    // memory is only visible by moving it into the working register
    task automatic readback(input logic [11:0] a, input logic [7:0] exp);
        send({4'hC, a});
        send(16'hFFE0);
        chk(working_register_o, exp);
    endtask
    task automatic t_literals;
        send(16'h0E5A);
        chk(working_register_o, 8'h5A);
        send(16'h01A5);
        chk(bank_select_register_o, 8'hA5);
        send(16'h0EE2);
        send(16'h0DC4);
        chk({product_high_o, product_low_o}, 16'hAD08);
        chk(working_register_o, 8'hE2);
        send(16'h0D00);
        chk({product_high_o, product_low_o}, 16'h0000);
        idle();
    endtask
    task automatic t_store;
        send(16'h0E4F);
        send(16'h6E10);
        chk(working_register_o, 8'h4F);
        send(16'h0E77);
        send(16'h6E90);
        send(16'h0E3B);
        send(16'h0105);
        send(16'h6F10);
        send(16'h0E00);
        readback(12'h010, 8'h4F);
        readback(12'hF90, 8'h77);
        readback(12'h510, 8'h3B);
        idle();
    endtask
    task automatic t_move;
        send(16'hC510);
        idle();
        chk(move_busy_o, 1'b1);
        send(16'hFFFF);
        chk(move_busy_o, 1'b0);
        send(16'h0EC6);
        send(16'hCFE0);
        send(16'hF000);
        readback(12'hFFF, 8'h3B);
        readback(12'h000, 8'hC6);
        idle();
    endtask
    task automatic t_refuse;
        send(16'h0E5D);
        for (int i = 1; i <= 4; i++)
        begin
            send({8'h6E, 8'hE0 + 8'(i)});
            send(16'hC000);
            send({4'hF, 12'hFE0 + 12'(i)});
            chk(illegal_dest_o, 1'b1);
        end
        idle();
        chk(illegal_dest_o, 1'b0);
        for (int i = 1; i <= 4; i++)
        begin
            readback(12'hFE0 + 12'(i), 8'h5D);
        end
        send(16'h0E11);
        send(16'hC000);
        send(16'h0E99);
        chk(move_broken_o, 1'b1);
        chk(working_register_o, 8'h11);
        idle();
    endtask
    initial
    begin
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int n = 0; n < 10 && instr_ready_o !== 1'b1; n++)
            @(negedge clock_i);
        if (instr_ready_o !== 1'b1)
        begin
            mismatches++;
        end
        else
        begin
            t_literals();
            t_store();
            t_move();
            t_refuse();
        end
        end_sim();
    end
endmodule
`default_nettype wire
